/* logic/smram_pkg.sv */
// Purpose: Constants for the SMM RAM access decode block
// Assumes: 8-bit configuration registers, 32-bit processor addresses
// Notes:   Shared by the decode core, register file and request decoder
//
// Contract
// - Open, closed, lock ignored unless global enable
// - Open and unlocked lets non-SMM reach DRAM
// - Closed denies SMM data, code still passes; the top segment ignores closed and passes SMM data
// - Lock clears open, freezes lock-covered fields
// - Lock set by write, cleared only by reset
// - Global enable maps 128 KB at A0000h
// - Global enable needed for extended functions
// - Base segment read-only, hardwired to 010
// - Compatible window untranslated, else to downstream
// - High alias remapped to low compatible range
// - Flag invalid high or top access outside SMM
// - Flag sticks until software writes one
// - Cacheable and cache enable bits read one
// - Top segment size 1, 2, 8 MB below stolen
// - Only SMM requests, or any request when open and unlocked, reach enabled top segment
// - Top segment active with both enables set
// - Top of DRAM supplies address bits 31:27
package smram_pkg;

    // ----------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TOP_LOW_USABLE_DRAM_OFS     = 8'h9c;
    localparam logic [7:0] SMM_RAM_CONTROL_OFS         = 8'h9d;
    localparam logic [7:0] EXTENDED_SMM_RAM_CONTROL_OFS = 8'h9e;
    localparam logic [7:0] SMM_RAM_CONTROL_RST         = 8'h02;
    localparam logic [7:0] EXTENDED_SMM_RAM_CONTROL_RST = 8'h38;
    localparam logic [4:0] TOP_LOW_USABLE_DRAM_RST     = 5'h01;

    // ----------------------------------------------------------------
    // Field positions, smm_ram_control
    // ----------------------------------------------------------------
    localparam int SPACE_OPEN_BIT   = 6;
    localparam int SPACE_CLOSED_BIT = 5;
    localparam int SPACE_LOCK_BIT   = 4;
    localparam int GLOBAL_EN_BIT    = 3;
    localparam logic [2:0] COMPAT_BASE_SEGMENT = 3'h2;

    // ----------------------------------------------------------------
    // Field positions, extended_smm_ram_control
    // ----------------------------------------------------------------
    localparam int HIGH_EN_BIT      = 7;
    localparam int INVALID_FLAG_BIT = 6;
    localparam int TOP_SEGMENT_SIZE_LSB    = 1;
    localparam int TOP_SEGMENT_ENABLE_BIT_BIT      = 0;
    localparam logic [2:0] CACHE_BITS_FIXED = 3'h7;

    // ----------------------------------------------------------------
    // Address windows
    // ----------------------------------------------------------------
    localparam logic [31:0] COMPAT_BASE = 32'h000a0000;
    localparam logic [31:0] COMPAT_LAST = 32'h000bffff;
    localparam logic [31:0] HIGH_BASE   = 32'hfeda0000;
    localparam logic [31:0] HIGH_LAST   = 32'hfedbffff;
    localparam logic [31:0] HIGH_TO_LOW = HIGH_BASE - COMPAT_BASE;
    localparam logic [31:0] MB_1        = 32'h00100000;
    localparam logic [31:0] MB_2        = 32'h00200000;
    localparam logic [31:0] MB_8        = 32'h00800000;

    // Route of a request
    typedef enum logic [1:0] {
        ROUTE_DRAM       = 2'b00,
        ROUTE_DOWNSTREAM = 2'b01,
        ROUTE_DENY       = 2'b11
    } route_e;

endpackage : smram_pkg

/* logic/smram_regs.sv */
// Purpose: Configuration registers for SMM RAM control
// Assumes: One-cycle config write/read strobes on the core clock
// Notes:   Lock is cleared only by rst_n_i
`timescale 1ns/100ps
module smram_regs
    import smram_pkg::*;
(
    input  wire logic       ref_clk_i,     // Core clock
    input  wire logic       rst_n_i,       // Full reset, async low
    input  wire logic       cfg_wr_i,      // Write strobe
    input  wire logic [7:0] cfg_addr_i,    // Register offset
    input  wire logic [7:0] cfg_wdata_i,   // Write data
    input  wire logic       invalid_set_i, // Invalid access event
    output logic            open_o,        // Space open
    output logic            closed_o,      // Space closed
    output logic            lock_o,        // Space lock
    output logic            global_en_o,   // Global enable
    output logic            high_en_o,     // High alias enable
    output logic            flag_o,        // Invalid access flag
    output logic [1:0]      top_segment_size_o,   // Top segment size
    output logic            top_segment_enable_bit_o,     // Top segment enable
    output logic [4:0]      top_low_usable_dram_o        // Top of low usable DRAM
);

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    logic wr_smc;   // Write to smm_ram_control
    logic wr_esmc;  // Write to extended register
    logic wr_top_low_usable_dram; // Write to top of DRAM
    assign wr_smc   = cfg_wr_i && (cfg_addr_i == SMM_RAM_CONTROL_OFS);
    assign wr_esmc  = cfg_wr_i && (cfg_addr_i == EXTENDED_SMM_RAM_CONTROL_OFS);
    assign wr_top_low_usable_dram = cfg_wr_i && (cfg_addr_i == TOP_LOW_USABLE_DRAM_OFS);

    // Lock: set by write, never cleared by software
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_o <= SMM_RAM_CONTROL_RST[SPACE_LOCK_BIT];
        end else if (wr_smc && cfg_wdata_i[SPACE_LOCK_BIT]) begin
            lock_o <= 1'b1;
        end
    end

    // Open: cleared by lock, frozen afterwards
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            open_o <= SMM_RAM_CONTROL_RST[SPACE_OPEN_BIT];
        end else if (wr_smc && !lock_o) begin
            // Lock written together with open still wins
            open_o <= cfg_wdata_i[SPACE_OPEN_BIT] && !cfg_wdata_i[SPACE_LOCK_BIT];
        end else if (lock_o) begin
            open_o <= 1'b0;
        end
    end

    // Closed stays writable; global enable freezes under lock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            closed_o    <= SMM_RAM_CONTROL_RST[SPACE_CLOSED_BIT];
            global_en_o <= SMM_RAM_CONTROL_RST[GLOBAL_EN_BIT];
        end else if (wr_smc) begin
            closed_o <= cfg_wdata_i[SPACE_CLOSED_BIT];
            if (!lock_o) begin
                global_en_o <= cfg_wdata_i[GLOBAL_EN_BIT];
            end
        end
    end

    // Extended fields, frozen once locked
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_en_o   <= EXTENDED_SMM_RAM_CONTROL_RST[HIGH_EN_BIT];
            top_segment_size_o <= EXTENDED_SMM_RAM_CONTROL_RST[TOP_SEGMENT_SIZE_LSB +: 2];
            top_segment_enable_bit_o   <= EXTENDED_SMM_RAM_CONTROL_RST[TOP_SEGMENT_ENABLE_BIT_BIT];
        end else if (wr_esmc && !lock_o) begin
            high_en_o   <= cfg_wdata_i[HIGH_EN_BIT];
            top_segment_size_o <= cfg_wdata_i[TOP_SEGMENT_SIZE_LSB +: 2];
            top_segment_enable_bit_o   <= cfg_wdata_i[TOP_SEGMENT_ENABLE_BIT_BIT];
        end
    end

    // Invalid flag: set wins over write-one clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= EXTENDED_SMM_RAM_CONTROL_RST[INVALID_FLAG_BIT];
        end else if (invalid_set_i) begin
            flag_o <= 1'b1;
        end else if (wr_esmc && cfg_wdata_i[INVALID_FLAG_BIT]) begin
            flag_o <= 1'b0;
        end
    end

    // Top of low usable DRAM, bits 31:27
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            top_low_usable_dram_o <= TOP_LOW_USABLE_DRAM_RST;
        end else if (wr_top_low_usable_dram) begin
            top_low_usable_dram_o <= cfg_wdata_i[7:3];
        end
    end

    // Lock never falls outside reset
    property p_lock_sticky;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        lock_o |=> lock_o;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit cleared without reset");

    // Once locked, open is low and frozen fields hold
    property p_lock_freeze;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 $past(lock_o) |-> !open_o && $stable(top_segment_size_o) && $stable(high_en_o)
            && $stable(top_segment_enable_bit_o) && $stable(global_en_o);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze)
        else $error("locked field changed");

    // Event and clear together keep the flag
    property p_flag_set;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        invalid_set_i |=> flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("invalid access flag not set");

    // Flag falls only on a write of one
    property p_flag_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        flag_o && !(wr_esmc && cfg_wdata_i[INVALID_FLAG_BIT]) |=> flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("invalid access flag dropped");

endmodule : smram_regs

/* logic/smram_route.sv */
// Purpose: Per-request SMM space routing decision
// Assumes: Control bits already registered
// Notes:   Purely combinational; caller registers the answer
`timescale 1ns/100ps
module smram_route
    import smram_pkg::*;
(
    input  wire logic [31:0] addr_i,     // Request address
    input  wire logic        smm_i,      // SMM attribute
    input  wire logic        code_i,     // Code fetch
    input  wire logic        open_i,     // Space open
    input  wire logic        closed_i,   // Space closed
    input  wire logic        lock_i,     // Space lock
    input  wire logic        global_i,   // Global enable
    input  wire logic        high_i,     // High enable
    input  wire logic [1:0]  tsize_i,    // Top segment size
    input  wire logic        ten_i,      // Top segment enable
    input  wire logic [4:0]  top_low_usable_dram_i,    // Top of DRAM bits 31:27
    input  wire logic [31:0] stolen_i,   // Graphics stolen bytes
    output route_e           route_o,    // Decision
    output logic [31:0]      dram_addr_o,// Translated address
    output logic             invalid_o   // Invalid access event
);

    // Top segment size in bytes; reserved code yields zero
    function automatic logic [31:0] top_segment_bytes(input logic [1:0] code);
        unique case (code)
            2'b00:   top_segment_bytes = MB_1;
            2'b01:   top_segment_bytes = MB_2;
            2'b10:   top_segment_bytes = MB_8;
            default: top_segment_bytes = 32'h0; // Reserved disables segment
        endcase
    endfunction : top_segment_bytes

    logic [31:0] top;      // First byte above usable DRAM
    logic [31:0] top_segment_top; // Top of segment
    logic [31:0] top_segment_bot; // Base of segment
    logic        in_comp;  // Compatible window hit
    logic        in_high;  // High alias hit
    logic        in_top_segment;  // Top segment hit
    logic        visible;  // SMM space visible for this request

    assign top      = {top_low_usable_dram_i, 27'h0};
    assign top_segment_top = top - stolen_i;
    assign top_segment_bot = top_segment_top - top_segment_bytes(tsize_i);
    assign in_comp  = (addr_i >= COMPAT_BASE) && (addr_i <= COMPAT_LAST);
    assign in_high  = (addr_i >= HIGH_BASE) && (addr_i <= HIGH_LAST);
    assign in_top_segment  = global_i && ten_i && (addr_i >= top_segment_bot)
                      && (addr_i < top_segment_top);

    // Controls only count with global enable
    always_comb begin
        visible = 1'b0;
        if (global_i) begin
            if (open_i && !lock_i) begin
                visible = 1'b1;
            end else if (smm_i) begin
                visible = code_i || !closed_i;
            end
        end
    end

    // Decision per request
    always_comb begin
        route_o     = ROUTE_DOWNSTREAM;
        dram_addr_o = addr_i;
        invalid_o   = 1'b0;
        if (in_comp) begin
            // Untranslated; downstream when hidden
            route_o = visible ? ROUTE_DRAM : ROUTE_DOWNSTREAM;
        end else if (in_high && global_i && high_i) begin
            if (visible) begin
                route_o     = ROUTE_DRAM;
                dram_addr_o = addr_i - HIGH_TO_LOW;
            end else begin
                route_o = ROUTE_DOWNSTREAM;
            end
            invalid_o = !smm_i && !open_i;
        end else if (in_top_segment) begin
            route_o   = (smm_i || (open_i && !lock_i)) ? ROUTE_DRAM
                                                        : ROUTE_DOWNSTREAM;
            invalid_o = !smm_i && !open_i;
        end else if (addr_i < top) begin
            route_o = ROUTE_DRAM;
        end
    end

endmodule : smram_route

/* logic/smram_access_decode.sv */
// Purpose: SMM RAM decode and protection top
// Assumes: Request valid is a one-cycle pulse from the host interface
// Notes:   Answer is registered, one cycle after the request
`timescale 1ns/100ps
module smram_access_decode
    import smram_pkg::*;
(
    input  wire logic        ref_clk_i,    // Core clock 125 MHz
    input  wire logic        rst_n_i,      // Full reset, async low
    input  wire logic        cfg_wr_i,     // Config write strobe
    input  wire logic        cfg_rd_i,     // Config read strobe
    input  wire logic [7:0]  cfg_addr_i,   // Config offset
    input  wire logic [7:0]  cfg_wdata_i,  // Config write data
    output logic [7:0]       cfg_rdata_o,  // Config read data
    input  wire logic        req_valid_i,  // Request strobe
    input  wire logic [31:0] req_addr_i,   // Request address
    input  wire logic        req_smm_i,    // SMM attribute
    input  wire logic        req_code_i,   // Code reference
    input  wire logic [31:0] stolen_size_i,// Graphics stolen size, bytes
    output logic             rsp_valid_o,  // Answer strobe
    output logic [1:0]       rsp_route_o,  // Route code
    output logic [31:0]      rsp_addr_o    // DRAM address
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic       open_b;     // Space open
    logic       closed_b;   // Space closed
    logic       lock_b;     // Space lock
    logic       global_b;   // Global enable
    logic       high_b;     // High enable
    logic       flag_b;     // Invalid flag
    logic [1:0] tsize_b;    // Top segment size
    logic       ten_b;      // Top segment enable
    logic [4:0] top_low_usable_dram_b;    // Top of DRAM
    logic       inv_event;  // Invalid access this cycle
    route_e     route;      // Decision
    logic [31:0] xaddr;     // Translated address
    logic        inv_raw;   // Decoder invalid indication

    smram_regs u_regs (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .cfg_wr_i      (cfg_wr_i),
        .cfg_addr_i    (cfg_addr_i),
        .cfg_wdata_i   (cfg_wdata_i),
        .invalid_set_i (inv_event),
        .open_o        (open_b),
        .closed_o      (closed_b),
        .lock_o        (lock_b),
        .global_en_o   (global_b),
        .high_en_o     (high_b),
        .flag_o        (flag_b),
        .top_segment_size_o   (tsize_b),
        .top_segment_enable_bit_o     (ten_b),
        .top_low_usable_dram_o       (top_low_usable_dram_b)
    );

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    smram_route u_route (
        .addr_i      (req_addr_i),
        .smm_i       (req_smm_i),
        .code_i      (req_code_i),
        .open_i      (open_b),
        .closed_i    (closed_b),
        .lock_i      (lock_b),
        .global_i    (global_b),
        .high_i      (high_b),
        .tsize_i     (tsize_b),
        .ten_i       (ten_b),
        .top_low_usable_dram_i     (top_low_usable_dram_b),
        .stolen_i    (stolen_size_i),
        .route_o     (route),
        .dram_addr_o (xaddr),
        .invalid_o   (inv_raw)
    );

    // Only a real request raises the flag
    assign inv_event = req_valid_i && inv_raw;

    // Answer registered per request
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_route_o <= ROUTE_DOWNSTREAM;
            rsp_addr_o  <= 32'h0;
        end else begin
            rsp_valid_o <= req_valid_i;
            if (req_valid_i) begin
                rsp_route_o <= route;
                rsp_addr_o  <= xaddr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Config read
    // ----------------------------------------------------------------
    // Registered read data; unmapped offsets read zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 8'h00;
        end else if (cfg_rd_i) begin
            unique case (cfg_addr_i)
                SMM_RAM_CONTROL_OFS:
                    cfg_rdata_o <= {1'b0, open_b, closed_b, lock_b, global_b,
                                    COMPAT_BASE_SEGMENT};
                EXTENDED_SMM_RAM_CONTROL_OFS:
                    cfg_rdata_o <= {high_b, flag_b, CACHE_BITS_FIXED,
                                    tsize_b, ten_b};
                TOP_LOW_USABLE_DRAM_OFS:
                    cfg_rdata_o <= {top_low_usable_dram_b, 3'h0};
                default:
                    cfg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Without global enable, compatible window never reaches DRAM
    property p_global_gate;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && !global_b && req_addr_i >= COMPAT_BASE
            && req_addr_i <= COMPAT_LAST
        |=> rsp_valid_o && rsp_route_o == ROUTE_DOWNSTREAM;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("compatible window reached DRAM while disabled");

    // Open and unlocked: non-SMM compatible access reaches DRAM
    property p_open_visible;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && global_b && open_b && !lock_b && !req_smm_i
            && req_addr_i >= COMPAT_BASE && req_addr_i <= COMPAT_LAST
        |=> rsp_route_o == ROUTE_DRAM && rsp_addr_o == $past(req_addr_i);
    endproperty
    a_open_visible: assert property (p_open_visible)
        else $error("open space not visible");

    // Closed denies data but not code
    property p_closed_data;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && global_b && closed_b && !open_b && req_smm_i
            && req_addr_i >= COMPAT_BASE && req_addr_i <= COMPAT_LAST
        |=> rsp_route_o == ($past(req_code_i) ? ROUTE_DRAM : ROUTE_DOWNSTREAM);
    endproperty
    a_closed_data: assert property (p_closed_data)
        else $error("closed space routing wrong");

    // High alias remaps for SMM
    property p_high_remap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && global_b && high_b && req_smm_i && !closed_b
            && req_addr_i >= HIGH_BASE && req_addr_i <= HIGH_LAST
        |=> rsp_route_o == ROUTE_DRAM
            && rsp_addr_o == $past(req_addr_i) - HIGH_TO_LOW;
    endproperty
    a_high_remap: assert property (p_high_remap)
        else $error("high alias not remapped");

    // Fixed read-only bits
    property p_fixed_bits;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_rd_i && cfg_addr_i == EXTENDED_SMM_RAM_CONTROL_OFS
        |=> cfg_rdata_o[5:3] == CACHE_BITS_FIXED;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("cache bits not one");

    // Base segment reads fixed
    property p_base_seg;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_rd_i && cfg_addr_i == SMM_RAM_CONTROL_OFS
        |=> cfg_rdata_o[2:0] == COMPAT_BASE_SEGMENT;
    endproperty
    a_base_seg: assert property (p_base_seg)
        else $error("base segment not hardwired");

    // Non-SMM high access outside open raises flag in the next cycle
    property p_invalid_flag;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && global_b && high_b && !req_smm_i && !open_b
            && req_addr_i >= HIGH_BASE && req_addr_i <= HIGH_LAST
        |=> flag_b ##0 rsp_route_o == ROUTE_DOWNSTREAM;
    endproperty
    a_invalid_flag: assert property (p_invalid_flag)
        else $error("invalid access not flagged");

    // Every answer comes one cycle after a request
    property p_one_answer;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rsp_valid_o |-> $past(req_valid_i);
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("answer without request");

endmodule : smram_access_decode

/* tb/far_side_model.sv */
// Purpose: Far-side model: DRAM and downstream link taking answers
// Assumes: Answer strobe lasts one cycle
// Notes:   Never stalls; counts DRAM-bound answers only
`timescale 1ns/100ps
module far_side_model (
    input  wire logic       ref_clk_i,   // Core clock
    input  wire logic       rst_n_i,     // Full reset
    input  wire logic       rsp_valid_i, // Answer strobe
    input  wire logic [1:0] rsp_route_i, // Route code
    output int              dram_hits_o  // Answers taken by DRAM
);
    // DRAM counts its hits; the link side just absorbs its traffic
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) dram_hits_o <= 0;
        else if (rsp_valid_i && rsp_route_i == 2'b00) dram_hits_o <= dram_hits_o + 1;
    end
endmodule : far_side_model

/* tb/tb_top.sv */
// Purpose: Directed bench for the SMM RAM decode block
// Assumes: Inputs move 1 ns after the rising edge
// Notes: Open and closed are never set together by this bench
`timescale 1ns/100ps
module tb_top;
    import smram_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, req_valid_i = 0;
    logic [7:0]  cfg_addr_i = 0, cfg_wdata_i = 0, cfg_rdata_o;
    logic        req_smm_i = 0, req_code_i = 0, rsp_valid_o;
    logic [31:0] req_addr_i = 0, stolen_size_i = 0, rsp_addr_o, base;
    logic [1:0]  rsp_route_o;
    logic [31:0] sz [3] = '{MB_1, MB_2, MB_8}; // Top segment sizes by code
    int failures = 0, checked = 0, cycles = 0, exp_dram = 0, dram_hits;
    always #4 ref_clk_i = ~ref_clk_i;          // 125 MHz
    smram_access_decode u_smram_access_decode (.*);
    far_side_model u_far_side_model (.ref_clk_i, .rst_n_i, .rsp_valid_i(rsp_valid_o),
        .rsp_route_i(rsp_route_o), .dram_hits_o(dram_hits));
    // Hang guard: whole run needs about 110 cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Config write (w=1) or read-and-compare (w=0), then one idle cycle
    task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] dt);
        cfg_addr_i = ad;
        cfg_wdata_i = dt;
        cfg_wr_i = w;
        cfg_rd_i = !w;
        @(posedge ref_clk_i) #1;
        cfg_wr_i = 0;
        cfg_rd_i = 0;
        if (!w) chk(cfg_rdata_o, dt);
        @(posedge ref_clk_i) #1;
    endtask : acc
    // One request; answer looked at in the cycle after it is taken
    task automatic rq(input logic [31:0] ad, input logic s, c, input logic [1:0] rt);
        req_addr_i = ad;
        req_smm_i = s;
        req_code_i = c;
        req_valid_i = 1;
        @(posedge ref_clk_i) #1;
        req_valid_i = 0;
        chk(rsp_valid_o, 1);
        chk(rsp_route_o, rt);
        if (rt == 2'b00) begin
            chk(rsp_addr_o, (ad >= HIGH_BASE) ? ad - HIGH_TO_LOW : ad);
            exp_dram++;
        end
        @(posedge ref_clk_i) #1;
    endtask : rq
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge ref_clk_i);
        #1 rst_n_i = 1;
        acc(0, 8'h9d, 8'h02);
        acc(0, 8'h9e, 8'h38);
        acc(0, 8'h9c, 8'h08);
        acc(0, 8'h9f, 8'h00);
        rq(32'h000a0010, 1, 0, 2'b01);
        acc(1, 8'h9d, 8'h40);
        rq(32'h000a0010, 0, 0, 2'b01);
        acc(1, 8'h9d, 8'h08);
        acc(0, 8'h9d, 8'h0a);
        rq(32'h000a0010, 1, 0, 2'b00);
        rq(32'h000bffff, 0, 0, 2'b01);
        acc(1, 8'h9d, 8'h48);
        rq(32'h000a0010, 0, 0, 2'b00);
        acc(1, 8'h9d, 8'h28);
        rq(32'h000a0010, 1, 0, 2'b01);
        rq(32'h000a0010, 1, 1, 2'b00);
        acc(1, 8'h9d, 8'h08);
        acc(1, 8'h9e, 8'h80);
        rq(32'hfeda0010, 1, 0, 2'b00);
        rq(32'hfeda0010, 0, 0, 2'b01);
        acc(0, 8'h9e, 8'hf8);
        acc(1, 8'h9e, 8'h80);
        acc(0, 8'h9e, 8'hf8);
        acc(1, 8'h9e, 8'hc0);
        acc(0, 8'h9e, 8'hb8);
        rq(32'h08000000, 0, 0, 2'b01);
        rq(32'h07f00000, 0, 0, 2'b00);
        // Each size code, with a growing stolen size between the segment top and the top of DRAM
        for (int i = 0; i < 3; i++) begin
            stolen_size_i = i * MB_1;
            base = 32'h08000000 - stolen_size_i - sz[i];
            acc(1, 8'h9e, 8'h81 | 8'(i << 1));
            rq(base, 0, 0, 2'b01);
            rq(base, 1, 0, 2'b00);
            rq(base - 1, 0, 0, 2'b00);
        end
        // Reserved size code leaves no segment, so the old range is plain DRAM
        acc(1, 8'h9e, 8'h87);
        rq(32'h07dfffff, 0, 0, 2'b00);
        acc(1, 8'h9e, 8'hc0);
        acc(1, 8'h9d, 8'h08);
        acc(1, 8'h9d, 8'h18);
        acc(0, 8'h9d, 8'h1a);
        acc(1, 8'h9d, 8'h40);
        acc(0, 8'h9d, 8'h1a);
        acc(1, 8'h9e, 8'h01);
        acc(0, 8'h9e, 8'hb8);
        acc(1, 8'h9d, 8'h28);
        acc(0, 8'h9d, 8'h3a);
        chk(dram_hits, exp_dram);
        // Mid-run full reset is the only way out of lock
        rst_n_i = 0;
        @(posedge ref_clk_i) #1;
        rst_n_i = 1;
        acc(0, 8'h9d, 8'h02);
        acc(0, 8'h9e, 8'h38);
        conclude();
    end
endmodule : tb_top
